//--- supply_ctrl_i2c_register_slave.sv
// Two-wire serial register slave of the supply controller
//
// Summary of operation
// R01: Master writes with start, chip address R/W=0, register address, data, stop.
// R02: Device acknowledges each received byte of its transfer by pulling data low.
// R03: Write transfer keeps accepting data bytes until a stop is seen.
// R04: Only control register at address 1 is writable; status is never written.
// R05: Master reads by setting address in one transfer, then opens R/W=1 transfer.
// R06: After read address acknowledge, device shifts out register; master ack advances address.
// R07: Read ends on master not-acknowledge then stop; device releases data line.
// R08: Read may start at address 0 or 1; master may stop after any ack.
// R09: Control register reads back the byte last written to it.
// R10: Control bits 0 to 2 form the output level code, bit 0 least significant.
// R11: Level code zero disables the output and selects standby.
// R12: Codes 1,2,3 give 13.000/13.333/13.667 V; 5,6,7 give 18.150/18.483/18.817 V.
// R13: Control bit 3 selects converter compensation, 1 for ceramic capacitors.
// R14: Master writes zero into reserved control bits 4 to 7.
// R15: Both registers clear to zero at power-on.
// R16: Status register at address 0 is read-only and holds diagnostic flags.
// R17: Status bit 0 is set while overload protection is triggered.
// R18: Status bit 1 is set while junction overtemperature is detected.
// R19: Status bit 2 is set while output voltage is below monitor thresholds.
// R20: Status bit 3 is set while input supply is below low-input threshold.
// R21: Status bit 4 is set while pull-down overcurrent outlasts its de-glitch time.
// R22: No acknowledge at all while supply is below lockout threshold.
// R23: Bytes are eight bits, most significant first, each followed by acknowledge.
// R24: Status flags are synchronised and captured when a status byte read begins.
// R25: Master should not write the undefined level code 100.
`timescale 1ns/1ps
`default_nettype none
module supply_ctrl_i2c_register_slave #(
  parameter logic [6:0] CHIP_ADDR = supply_ctrl_pkg::CHIP_ADDR_DEFAULT
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic overload_flag,
  input  wire logic overtemperature_flag,
  input  wire logic output_voltage_monitor_flag,
  input  wire logic input_supply_low_flag,
  input  wire logic pulldown_overcurrent_flag,
  input  wire logic supply_under_lockout,
  output logic      output_level_code_bit0,
  output logic      output_level_code_bit1,
  output logic      output_level_code_bit2,
  output logic      compensation_select,
  output logic      standby
);

  supply_ctrl_pkg::sys_s        sys_r;
  supply_ctrl_pkg::sys_s        sys_nxt;
  supply_ctrl_pkg::link_s       link_r;
  supply_ctrl_pkg::link_s       link_nxt;
  supply_ctrl_pkg::ctrl_s       ctrl;
  supply_ctrl_pkg::ctrl_s       ctrl_link;
  supply_ctrl_pkg::diag_flags_s status;
  supply_ctrl_pkg::diag_flags_s status_link;
  supply_ctrl_pkg::diag_flags_s flags_sync;
  logic                         scl_s;
  logic                         sda_s;
  logic                         lockout_s;
  logic                         start_seen;
  logic                         stop_seen;
  logic [7:0]                   ptr_r;
  logic [7:0]                   ptr_nxt;
  logic [7:0]                   byte_in;
  logic [7:0]                   next_byte;
  logic                         sda_oe_r;

  // Register contents as seen from the link side
  function automatic logic [7:0] reg_byte(
    input logic [7:0]                  addr,
    input supply_ctrl_pkg::ctrl_s       c,
    input supply_ctrl_pkg::diag_flags_s s
  );
    logic [7:0] value;
    value = supply_ctrl_pkg::UNMAPPED_READ;
    if (addr == supply_ctrl_pkg::ADDR_STATUS)
    begin
      value = {3'h0, s};                                                // R16
    end
    else if (addr == supply_ctrl_pkg::ADDR_CONTROL)
    begin
      value = c;                                                        // R09
    end
    return value;
  endfunction

  // mclk domain: pin synchronisers
  bit_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (mclk),
    .rst_n (resetn),
    .d     ({scl, sda_in}),
    .q     ({scl_s, sda_s})
  );

  bit_sync #(
    .WIDTH (6)
  ) u_flag_sync (
    .clk   (mclk),
    .rst_n (resetn),
    .d     ({supply_under_lockout, pulldown_overcurrent_flag, input_supply_low_flag,
             output_voltage_monitor_flag, overtemperature_flag, overload_flag}),
    .q     ({lockout_s, flags_sync})                                    // R17 R18 R19 R20 R21 R24
  );

  // Start and stop detection, frame gating of the link side
  assign start_seen = scl_s && sys_r.sda_prev && !sda_s;
  assign stop_seen  = scl_s && !sys_r.sda_prev && sda_s;

  always_comb
  begin
    sys_nxt            = sys_r;
    sys_nxt.sda_prev   = sda_s;
    sys_nxt.boot_clear = 1'b0;
    sys_nxt.sda_level  = 1'b0;
    if (stop_seen || lockout_s)
    begin
      sys_nxt.link_clear = 1'b1;                                        // R03 R07 R22
    end
    else if (start_seen)
    begin
      sys_nxt.link_clear = 1'b0;
    end
    if (!resetn)
    begin
      sys_nxt.sda_prev   = 1'b1;
      sys_nxt.link_clear = 1'b1;
      sys_nxt.boot_clear = 1'b1;
      sys_nxt.sda_level  = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    sys_r <= sys_nxt;
  end

  control_status_regs u_regs (
    .mclk       (mclk),
    .resetn     (resetn),
    .wr_flag    (link_r.wr_flag),
    .wr_data    (link_r.wr_data),
    .flags_sync (flags_sync),
    .ctrl       (ctrl),
    .status     (status),
    .standby    (standby)
  );

  // Link domain: register values brought onto the serial clock
  bit_sync #(
    .WIDTH (8)
  ) u_ctrl_sync (
    .clk   (scl),
    .rst_n (1'b1),
    .d     (ctrl),
    .q     (ctrl_link)
  );

  bit_sync #(
    .WIDTH (supply_ctrl_pkg::FLAG_COUNT)
  ) u_status_sync (
    .clk   (scl),
    .rst_n (1'b1),
    .d     (status),
    .q     (status_link)
  );

  assign byte_in   = {link_r.rx[6:0], sda_in};                         // R23
  assign next_byte = reg_byte(ptr_r + 8'h01, ctrl_link, status_link);

  always_comb
  begin
    link_nxt         = link_r;
    ptr_nxt          = ptr_r;
    link_nxt.wr_flag = 1'b0;
    link_nxt.drive   = 1'b0;
    if (link_r.bit_pos == supply_ctrl_pkg::ACK_CELL)
    begin
      link_nxt.bit_pos = 4'h0;
    end
    else
    begin
      link_nxt.bit_pos = link_r.bit_pos + 4'h1;
      link_nxt.rx      = byte_in;                                       // R23
    end
    if (link_r.bit_pos < supply_ctrl_pkg::LAST_DATA_CELL)
    begin
      if (link_r.phase == supply_ctrl_pkg::PH_READ_DATA)
      begin
        link_nxt.tx    = {link_r.tx[6:0], 1'b0};
        link_nxt.drive = !link_nxt.tx[7];                               // R06 R23
      end
    end
    else if (link_r.bit_pos == supply_ctrl_pkg::LAST_DATA_CELL)
    begin
      unique case (link_r.phase)
        supply_ctrl_pkg::PH_CHIP_ADDR:
        begin
          if (byte_in[7:1] == CHIP_ADDR)
          begin
            link_nxt.drive = 1'b1;                                      // R02
            link_nxt.rd    = byte_in[0];
          end
          else
          begin
            link_nxt.phase = supply_ctrl_pkg::PH_IGNORE;
          end
        end
        supply_ctrl_pkg::PH_REG_ADDR:
        begin
          ptr_nxt        = byte_in;                                     // R08
          link_nxt.drive = 1'b1;                                        // R02
        end
        supply_ctrl_pkg::PH_WRITE_DATA:
        begin
          link_nxt.drive = 1'b1;                                        // R02 R03
          if (ptr_r == supply_ctrl_pkg::ADDR_CONTROL)
          begin
            link_nxt.wr_data = byte_in;                                 // R04 R10 R13
            link_nxt.wr_flag = 1'b1;                                    // R04
          end
        end
        supply_ctrl_pkg::PH_READ_DATA:
        begin
          link_nxt.drive = 1'b0;
        end
        supply_ctrl_pkg::PH_IGNORE:
        begin
          link_nxt.drive = 1'b0;
        end
      endcase
    end
    else
    begin
      unique case (link_r.phase)
        supply_ctrl_pkg::PH_CHIP_ADDR:
        begin
          if (link_r.rd)
          begin
            link_nxt.phase = supply_ctrl_pkg::PH_READ_DATA;             // R06
            link_nxt.tx    = reg_byte(ptr_r, ctrl_link, status_link);   // R06 R24
            link_nxt.drive = !link_nxt.tx[7];
          end
          else
          begin
            link_nxt.phase = supply_ctrl_pkg::PH_REG_ADDR;
          end
        end
        supply_ctrl_pkg::PH_REG_ADDR:
        begin
          link_nxt.phase = supply_ctrl_pkg::PH_WRITE_DATA;
        end
        supply_ctrl_pkg::PH_WRITE_DATA:
        begin
          link_nxt.phase = supply_ctrl_pkg::PH_WRITE_DATA;              // R03
        end
        supply_ctrl_pkg::PH_READ_DATA:
        begin
          if (!sda_in)
          begin
            ptr_nxt        = ptr_r + 8'h01;                             // R06
            link_nxt.tx    = next_byte;                                 // R06 R24
            link_nxt.drive = !next_byte[7];
          end
          else
          begin
            link_nxt.phase = supply_ctrl_pkg::PH_IGNORE;                // R07
          end
        end
        supply_ctrl_pkg::PH_IGNORE:
        begin
          link_nxt.phase = supply_ctrl_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // Link engine restarts on each start that follows a stop or lockout, not on a repeated start; held cleared outside frames
  always_ff @(posedge scl or posedge sys_r.link_clear)
  begin
    if (sys_r.link_clear)
    begin
      link_r <= '0;
    end
    else
    begin
      link_r <= link_nxt;
    end
  end

  // Address pointer survives between frames
  always_ff @(posedge scl or posedge sys_r.boot_clear)
  begin
    if (sys_r.boot_clear)
    begin
      ptr_r <= supply_ctrl_pkg::ADDR_STATUS;
    end
    else
    begin
      ptr_r <= ptr_nxt;
    end
  end

  // Data line taken only on the falling clock edge; released at once by link_clear, even while the clock is high
  always_ff @(negedge scl or posedge sys_r.link_clear)
  begin
    if (sys_r.link_clear)
    begin
      sda_oe_r <= 1'b0;                                                 // R07 R22
    end
    else
    begin
      sda_oe_r <= link_r.drive;                                         // R02
    end
  end

  assign sda_oe                 = sda_oe_r;
  assign sda_out                = sys_r.sda_level;
  assign output_level_code_bit0 = ctrl.level_code[0];                  // R10 R12
  assign output_level_code_bit1 = ctrl.level_code[1];                  // R10 R12
  assign output_level_code_bit2 = ctrl.level_code[2];                  // R10 R12
  assign compensation_select    = ctrl.compensation;                   // R13

endmodule
`default_nettype wire

//--- supply_ctrl_pkg.sv
// Shared constants and types of the supply controller serial register slave
package supply_ctrl_pkg;

  // Byte framing: eight data cells then one acknowledge cell
  localparam int         BYTE_BITS      = 8;
  localparam logic [3:0] LAST_DATA_CELL = 4'h7;
  localparam logic [3:0] ACK_CELL       = 4'h8;

  // Internal register addresses
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_CONTROL   = 8'h01;

  // Reset values and read value of unmapped addresses
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Chip address default, value arbitrary
  localparam logic [6:0] CHIP_ADDR_DEFAULT = 7'h08;

  // Control register field positions
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 2;
  localparam int COMP_BIT = 3;

  // Status register field positions
  localparam int OVERLOAD_BIT    = 0;
  localparam int OVERTEMP_BIT    = 1;
  localparam int OUTPUT_VOLTAGE_MONITOR_FLAG_BIT        = 2;
  localparam int SUPPLY_LOW_BIT  = 3;
  localparam int PULLDOWN_OC_BIT = 4;
  localparam int FLAG_COUNT      = 5;

  // Output level codes
  localparam logic [2:0] CODE_STANDBY   = 3'h0;
  localparam logic [2:0] CODE_13V000    = 3'h1;
  localparam logic [2:0] CODE_13V333    = 3'h2;
  localparam logic [2:0] CODE_13V667    = 3'h3;
  localparam logic [2:0] CODE_UNDEFINED = 3'h4;
  localparam logic [2:0] CODE_18V150    = 3'h5;
  localparam logic [2:0] CODE_18V483    = 3'h6;
  localparam logic [2:0] CODE_18V817    = 3'h7;

  typedef struct packed {
    logic [3:0] reserved;
    logic       compensation;
    logic [2:0] level_code;
  } ctrl_s;

  typedef struct packed {
    logic pulldown_overcurrent_flag;
    logic input_supply_low_flag;
    logic output_voltage_monitor_flag;
    logic overtemperature_flag;
    logic overload_flag;
  } diag_flags_s;

  typedef enum logic [2:0] {
    PH_CHIP_ADDR,
    PH_REG_ADDR,
    PH_WRITE_DATA,
    PH_READ_DATA,
    PH_IGNORE
  } phase_e;

  // Link-side state, clocked by the serial clock
  typedef struct packed {
    phase_e     phase;
    logic [3:0] bit_pos;
    logic [7:0] rx;
    logic [7:0] tx;
    logic       rd;
    logic       drive;
    logic       wr_flag;
    logic [7:0] wr_data;
  } link_s;

  // System-side state, clocked by mclk
  typedef struct packed {
    logic sda_prev;
    logic link_clear;
    logic boot_clear;
    logic sda_level;
  } sys_s;

  typedef struct packed {
    ctrl_s       ctrl;
    diag_flags_s status;
    logic        standby;
    logic        wr_seen;
  } regs_s;

endpackage

//--- bit_sync.sv
// Two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        meta_r[i] <= 1'b0;
        q[i]      <= 1'b0;
      end
      else
      begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- control_status_regs.sv
// Control and status registers in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module control_status_regs (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        wr_flag,
  input  wire logic [7:0]                  wr_data,
  input  wire supply_ctrl_pkg::diag_flags_s flags_sync,
  output supply_ctrl_pkg::ctrl_s           ctrl,
  output supply_ctrl_pkg::diag_flags_s     status,
  output logic                             standby
);

  supply_ctrl_pkg::regs_s regs_r;
  supply_ctrl_pkg::regs_s regs_nxt;
  logic                   wr_sync;

  // Write strobe from the link side, level held for one serial clock
  bit_sync #(
    .WIDTH (1)
  ) u_wr_sync (
    .clk   (mclk),
    .rst_n (resetn),
    .d     (wr_flag),
    .q     (wr_sync)
  );

  always_comb
  begin
    regs_nxt         = regs_r;
    regs_nxt.wr_seen = wr_sync;
    regs_nxt.status  = flags_sync;                                      // R24
    if (wr_sync && !regs_r.wr_seen)
    begin
      regs_nxt.ctrl = supply_ctrl_pkg::ctrl_s'(wr_data);               // R09
    end
    regs_nxt.standby = (regs_nxt.ctrl.level_code == supply_ctrl_pkg::CODE_STANDBY); // R11
    if (!resetn)
    begin
      regs_nxt.ctrl    = supply_ctrl_pkg::ctrl_s'(supply_ctrl_pkg::CONTROL_RESET);       // R15
      regs_nxt.status  = supply_ctrl_pkg::diag_flags_s'(
                           supply_ctrl_pkg::STATUS_RESET[supply_ctrl_pkg::FLAG_COUNT-1:0]); // R15
      regs_nxt.standby = 1'b1;
      regs_nxt.wr_seen = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    regs_r <= regs_nxt;
  end

  assign ctrl    = regs_r.ctrl;
  assign status  = regs_r.status;
  assign standby = regs_r.standby;

endmodule
`default_nettype wire

//--- supply_ctrl_i2c_register_slave_assertions.sv
// Concurrent checks on the serial register slave ports
`timescale 1ns/1ps
`default_nettype none
module supply_ctrl_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic supply_under_lockout,
  input wire logic output_level_code_bit0,
  input wire logic output_level_code_bit1,
  input wire logic output_level_code_bit2,
  input wire logic compensation_select,
  input wire logic standby
);
  wire logic [2:0] code = {output_level_code_bit2, output_level_code_bit1, output_level_code_bit0};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_reset_clear: assert property (
    !$past(resetn) |-> code == 3'h0 && !compensation_select && standby && !sda_oe)
    else $error("outputs not cleared after reset");
  a_standby_on: assert property ((code == 3'h0) [*3] |-> standby)
    else $error("standby low with zero code");
  a_standby_off: assert property ((code != 3'h0) [*3] |-> !standby)
    else $error("standby high with nonzero code");
  a_lockout_no_ack: assert property (supply_under_lockout [*4] |-> !sda_oe)
    else $error("data line driven under lockout");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("data line taken while clock high");
  a_oe_bounded: assert property ($rose(sda_oe) |-> ##[1:100] !sda_oe)
    else $error("data line held too long");
  a_stop_release: assert property (scl && $rose(sda_in) |-> ##1 (!sda_oe) [*4])
    else $error("data line driven after stop");
  a_idle_stable: assert property (
    (scl && sda_in) [*8] |-> $stable(code) && $stable(compensation_select))
    else $error("control changed on idle bus");

  c_ack: cover property ($rose(sda_oe));
  c_code_set: cover property ($fell(standby));
  c_lockout: cover property (supply_under_lockout && !scl);
endmodule

bind supply_ctrl_i2c_register_slave supply_ctrl_assertions u_chk (
  .mclk, .resetn, .scl, .sda_in, .sda_out, .sda_oe, .supply_under_lockout,
  .output_level_code_bit0, .output_level_code_bit1, .output_level_code_bit2,
  .compensation_select, .standby);
`default_nettype wire

//--- i2c_host_model.sv
// Bus master model driving the serial clock and data line
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  output logic     scl,
  output logic     sda_low,
  input wire logic sda_line
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One bit cell of 80 ns, sampled mid high phase
  task automatic bit_cell(input logic pull, output logic seen);
    sda_low = pull;
    #20 scl = 1'b1;
    #20 seen = sda_line;
    #20 scl = 1'b0;
    #20;
  endtask

  task automatic start();
    #43 sda_low = 1'b1;
    #80 scl = 1'b0;
    #20;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #40 sda_low = 1'b0;
    #80;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cell(~b[i], s);
    bit_cell(1'b0, s);
    ack = ~s;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cell(1'b0, b[i]);
    bit_cell(~last, s);
  endtask
endmodule
`default_nettype wire

//--- supply_ctrl_i2c_register_slave_tb.sv
// Self-checking bench of the serial register slave
`timescale 1ns/1ps
`default_nettype none
module supply_ctrl_i2c_register_slave_tb;
  localparam logic [6:0] CA = supply_ctrl_pkg::CHIP_ADDR_DEFAULT;
  logic       mclk;
  logic       resetn;
  logic       supply_under_lockout;
  logic [4:0] flags;
  logic [7:0] got [2];
  logic [7:0] d;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  int         errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  wire logic  scl, host_low, sda_line, sda_out, sda_oe;
  wire logic  code0, code1, code2, comp, standby;

  assign sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  i2c_host_model u_host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));

  supply_ctrl_i2c_register_slave #(.CHIP_ADDR(CA)) u_dut (
    .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .overload_flag(flags[0]), .overtemperature_flag(flags[1]),
    .output_voltage_monitor_flag(flags[2]), .input_supply_low_flag(flags[3]),
    .pulldown_overcurrent_flag(flags[4]), .supply_under_lockout(supply_under_lockout),
    .output_level_code_bit0(code0), .output_level_code_bit1(code1),
    .output_level_code_bit2(code2), .compensation_select(comp), .standby(standby));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic outs(input logic [3:0] e);
    check({4'h0, comp, code2, code1, code0}, {4'h0, e});
    check({7'h0, standby}, {7'h0, e[2:0] == 3'h0});
  endtask

  task automatic wr(input logic [6:0] ca, input logic [7:0] ra, input logic [15:0] dd,
                    input int n, input logic ex);
    logic a;
    @(negedge mclk);
    u_host.start();
    u_host.send({ca, 1'b0}, a);
    check({7'h0, a}, {7'h0, ex});
    u_host.send(ra, a);
    check({7'h0, a}, {7'h0, ex});
    for (int i = n; i > 0; i--)
    begin
      u_host.send(dd[8*i-1 -: 8], a);
      check({7'h0, a}, {7'h0, ex});
    end
    u_host.stop();
    repeat (10) @(negedge mclk);
  endtask

  task automatic rd(input logic [7:0] ra, input int n);
    logic a;
    wr(CA, ra, 16'h0000, 0, 1'b1);
    u_host.start();
    u_host.send({CA, 1'b1}, a);
    check({7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) u_host.recv(i == n - 1, got[i]);
    u_host.stop();
    repeat (10) @(negedge mclk);
    check({7'h0, sda_oe}, 8'h00);
  endtask

  initial
  begin
    resetn = 1'b0;
    supply_under_lockout = 1'b0;
    flags = 5'h00;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    outs(4'h0);
    rd(8'h00, 2);
    check(got[0], 8'h00);
    check(got[1], 8'h00);
    foreach (codes[k])
    begin
      d = {4'h0, k[0], codes[k]};
      wr(CA, 8'h01, {8'h00, d}, 1, 1'b1);
      outs(d[3:0]);
      rd(8'h01, 1);
      check(got[0], d);
    end
    wr(CA, 8'h01, 16'h0306, 2, 1'b1);
    outs(4'h6);
    wr(CA, 8'h00, 16'h000F, 1, 1'b1);
    outs(4'h6);
    for (int i = 0; i < 5; i++)
    begin
      @(negedge mclk) flags = 5'h01 << i;
      rd(8'h00, 2);
      check(got[0], {3'h0, flags});
      check(got[1], 8'h06);
    end
    @(negedge mclk) flags = 5'h00;
    wr(CA ^ 7'h01, 8'h01, 16'h0001, 1, 1'b0);
    outs(4'h6);
    @(negedge mclk) supply_under_lockout = 1'b1;
    repeat (5) @(negedge mclk);
    wr(CA, 8'h01, 16'h0001, 1, 1'b0);
    outs(4'h6);
    supply_under_lockout = 1'b0;
    repeat (5) @(negedge mclk);
    resetn = 1'b0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    outs(4'h0);
    rd(8'h01, 2);
    check(got[0], 8'h00);
    check(got[1], supply_ctrl_pkg::UNMAPPED_READ);
    test_done();
  end
endmodule
`default_nettype wire
